// file: verilog/dcic_pkg.sv
/*
  Package of the data-clock input control block: register addresses, reset
  values, write masks, register field layouts, serial port states and timing.
  Assumes a 40 MHz core clock and a 16-bit serial frame (R/W, 7-bit address,
  8-bit data, most significant bit first).
*/
package dcic_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [6:0] ADDR_SCLK_CTRL = 7'h02;
  localparam logic [6:0] ADDR_DCLK_CTRL = 7'h03;
  localparam logic [7:0] SCLK_CTRL_RST = 8'h00;
  localparam logic [7:0] DCLK_CTRL_RST = 8'h00;
  // Only writable bits survive a write; status and reserved bits stay zero
  localparam logic [7:0] SCLK_WR_MASK = 8'hf1;
  localparam logic [7:0] DCLK_WR_MASK = 8'h75;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  typedef struct packed {
    logic term_on;
    logic drive_sel;
    logic ratio_sel;
    logic out_disable;
    logic [1:0] rsvd;
    logic present;
    logic powerdown;
  } dcic_sclk_reg_t;

  typedef struct packed {
    logic rsvd_hi;
    logic [2:0] delay_trim;
    logic rsvd_lo;
    logic quad_sel;
    logic present;
    logic rx_enable;
  } dcic_dclk_reg_t;

  typedef enum {DCIC_SPI_HDR, DCIC_SPI_DATA, DCIC_SPI_DONE} dcic_spi_st_t;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int DET_WIN_NS = 1000;
  localparam int DET_WIN_CYC = (DET_WIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCLK_MIN_MHZ = 50;
  localparam int DCLK_MIN_MHZ = 25;
  localparam int SCLK_MIN_EDGES = SCLK_MIN_MHZ * DET_WIN_NS / 1000;
  localparam int DCLK_MIN_EDGES = DCLK_MIN_MHZ * DET_WIN_NS / 1000;
  localparam int DLY_BASE_PS = 400;
  localparam int DLY_STEP_PS = 85;
  localparam int SPI_PHASE_BITS = 8;

endpackage

// file: verilog/dcic_clk_detect.sv
/*
  Clock presence detector: counts rising edges of a sampled clock over a
  fixed window and flags presence when enough edges were seen.
  Assumes the watched clock is already synchronous to the core clock.
*/
`timescale 1ns/1ps
module dcic_clk_detect
  import dcic_pkg::*;
#(
  parameter int WIN_CYC = DET_WIN_CYC,
  parameter int MIN_EDGES = SCLK_MIN_EDGES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched clock
  input wire logic enable,
  input wire logic clk_smp,
  // Result
  output logic present
);

  localparam int CW = $clog2(WIN_CYC + 1);
  localparam logic [CW-1:0] WIN_LAST = CW'(WIN_CYC - 1);
  localparam logic [CW-1:0] EDGE_MIN = CW'(MIN_EDGES);

  logic prev_q, prev_d;
  logic [CW-1:0] win_q, win_d;
  logic [CW-1:0] edges_q, edges_d;
  logic present_q, present_d;

  always_comb
  begin
    prev_d = clk_smp;
    win_d = win_q + 1'b1;
    edges_d = edges_q;
    present_d = present_q;
    if (clk_smp && !prev_q && edges_q != '1)
    begin
      edges_d = edges_q + 1'b1;
    end
    if (!enable)
    begin
      // A powered-down receiver reports no clock at once
      win_d = '0;
      edges_d = '0;
      present_d = 1'b0;
    end
    else if (win_q == WIN_LAST)
    begin
      // Judge before clearing, so an edge in the last cycle still counts
      present_d = (edges_d >= EDGE_MIN);
      win_d = '0;
      edges_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= 1'b0;
      win_q <= '0;
      edges_q <= '0;
      present_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      win_q <= win_d;
      edges_q <= edges_d;
      present_q <= present_d;
    end
  end

  assign present = present_q;

  a_det_off: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> !present)
    else $error("clock reported present while receiver is off");

endmodule // dcic_clk_detect

// file: verilog/dcic_top.sv
/*
  Clock-side control of the converter: serial register port for the sample
  clock / divided clock output register and the data clock input register,
  both clock presence detectors, the divide-by-2/4 clock output, DDR capture
  of data words and the data clock delay setting.
  Assumes all pins are synchronous to MCLK_IN and the host keeps clock ratios.
*/
`timescale 1ns/1ps
module dcic_top
  import dcic_pkg::*;
#(
  parameter int CODE_W = 16,
  parameter int WIN_CYC_P = DET_WIN_CYC,
  parameter int SCLK_EDGES_P = SCLK_MIN_EDGES,
  parameter int DCLK_EDGES_P = DCLK_MIN_EDGES
)
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // Serial register port
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_SCK_IN,
  input wire logic SPI_SDI_IN,
  output logic SPI_SDO_OUT,
  output logic SPI_SDO_OE_N_OUT,
  // Clocks and data from outside
  input wire logic SAMPLE_CLOCK_IN,
  input wire logic LVDS_DATA_CLOCK_IN,
  input wire logic [CODE_W-1:0] DATA_PORT_IN,
  input wire logic PATTERN_GEN_ENABLE_IN,
  // Divided clock output
  output logic DIVIDED_CLOCK_OUT,
  output logic DIVCLK_OE_N_OUT,
  output logic DIVCLK_DRIVE_HI_OUT,
  output logic DIVCLK_TERM_ON_OUT,
  // Data path
  output logic [CODE_W-1:0] DAC_CODE_OUT,
  output logic CODE_STROBE_OUT,
  output logic DATAPATH_RESET_OUT,
  output logic [9:0] DCLK_DELAY_PS_OUT
);

  // ************************************************************
  // Clock detectors
  // ************************************************************
  logic sclk_ok, dclk_ok;
  dcic_sclk_reg_t sclk_reg_q, sclk_reg_d;
  dcic_dclk_reg_t dclk_reg_q, dclk_reg_d;

  dcic_clk_detect #(.WIN_CYC(WIN_CYC_P), .MIN_EDGES(SCLK_EDGES_P)) u_sclk_det (
    .clk(MCLK_IN),
    .rst_n(RSTN_IN),
    .enable(!sclk_reg_q.powerdown),
    .clk_smp(SAMPLE_CLOCK_IN),
    .present(sclk_ok)
  );

  dcic_clk_detect #(.WIN_CYC(WIN_CYC_P), .MIN_EDGES(DCLK_EDGES_P)) u_dclk_det (
    .clk(MCLK_IN),
    .rst_n(RSTN_IN),
    .enable(dclk_reg_q.rx_enable),
    .clk_smp(LVDS_DATA_CLOCK_IN),
    .present(dclk_ok)
  );

  // ************************************************************
  // Serial port
  // ************************************************************
  dcic_spi_st_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [6:0] sh_q, sh_d;
  logic rw_q, rw_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] rd_q, rd_d;
  logic sck_q;
  logic sdo_q, sdo_d;
  logic oe_n_q, oe_n_d;
  logic wr_go, rd_load;
  logic [7:0] wdata, rd_val;
  logic sck_rise, sck_fall;

  assign sck_rise = !SPI_CS_N_IN && SPI_SCK_IN && !sck_q;
  assign sck_fall = !SPI_CS_N_IN && !SPI_SCK_IN && sck_q;
  assign wdata = {sh_q, SPI_SDI_IN};

  // Status bits are inserted live so a read shows the detector now
  always_comb
  begin
    dcic_sclk_reg_t s;
    dcic_dclk_reg_t d;
    s = sclk_reg_q;
    d = dclk_reg_q;
    s.present = sclk_ok;
    d.present = dclk_ok;
    unique case (addr_d)
      ADDR_SCLK_CTRL: rd_val = s;
      ADDR_DCLK_CTRL: rd_val = d;
      default: rd_val = RD_UNMAPPED;
    endcase
  end

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rw_d = rw_q;
    addr_d = addr_q;
    rd_d = rd_q;
    sdo_d = sdo_q;
    wr_go = 1'b0;
    rd_load = 1'b0;
    if (SPI_CS_N_IN)
    begin
      st_d = DCIC_SPI_HDR;
      cnt_d = '0;
    end
    else if (sck_rise && st_q != DCIC_SPI_DONE)
    begin
      sh_d = wdata[6:0];
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == 3'(SPI_PHASE_BITS - 1))
      begin
        unique case (st_q)
          DCIC_SPI_HDR:
          begin
            rw_d = sh_q[6];
            addr_d = wdata[6:0];
            rd_load = 1'b1;
            st_d = DCIC_SPI_DATA;
          end
          DCIC_SPI_DATA:
          begin
            wr_go = !rw_q;
            st_d = DCIC_SPI_DONE;
          end
          DCIC_SPI_DONE:
          begin
            st_d = DCIC_SPI_DONE;
          end
        endcase
      end
    end
    if (rd_load)
    begin
      rd_d = rd_val;
    end
    else if (sck_fall && st_q == DCIC_SPI_DATA)
    begin
      sdo_d = rd_q[7];
      rd_d = {rd_q[6:0], 1'b0};
    end
    oe_n_d = !(!SPI_CS_N_IN && rw_d && st_d != DCIC_SPI_HDR);
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      st_q <= DCIC_SPI_HDR;
      cnt_q <= '0;
      sh_q <= '0;
      rw_q <= 1'b0;
      addr_q <= '0;
      rd_q <= '0;
      sck_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rw_q <= rw_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      sck_q <= SPI_SCK_IN;
      sdo_q <= sdo_d;
      oe_n_q <= oe_n_d;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_comb
  begin
    sclk_reg_d = sclk_reg_q;
    dclk_reg_d = dclk_reg_q;
    if (wr_go && addr_q == ADDR_SCLK_CTRL)
    begin
      sclk_reg_d = dcic_sclk_reg_t'(wdata & SCLK_WR_MASK);
    end
    if (wr_go && addr_q == ADDR_DCLK_CTRL)
    begin
      dclk_reg_d = dcic_dclk_reg_t'(wdata & DCLK_WR_MASK);
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      sclk_reg_q <= dcic_sclk_reg_t'(SCLK_CTRL_RST);
      dclk_reg_q <= dcic_dclk_reg_t'(DCLK_CTRL_RST);
    end
    else
    begin
      sclk_reg_q <= sclk_reg_d;
      dclk_reg_q <= dclk_reg_d;
    end
  end

  // ************************************************************
  // Divided clock output
  // ************************************************************
  logic sclk_prev_q, div_cnt_q, div_cnt_d, div_q, div_d, sclk_rise;
  logic oe_div_n_q, oe_div_n_d, drv_q, term_q;

  assign sclk_rise = SAMPLE_CLOCK_IN && !sclk_prev_q && !sclk_reg_q.powerdown;

  always_comb
  begin
    div_cnt_d = div_cnt_q;
    div_d = div_q;
    if (sclk_rise)
    begin
      // Ratio one toggles every sample edge, ratio zero every second one
      div_cnt_d = !div_cnt_q;
      if (sclk_reg_q.ratio_sel || div_cnt_q)
      begin
        div_d = !div_q;
      end
    end
    oe_div_n_d = sclk_reg_q.out_disable;
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      sclk_prev_q <= 1'b0;
      div_cnt_q <= 1'b0;
      div_q <= 1'b0;
      oe_div_n_q <= 1'b0;
      drv_q <= 1'b0;
      term_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= SAMPLE_CLOCK_IN;
      div_cnt_q <= div_cnt_d;
      div_q <= div_d;
      oe_div_n_q <= oe_div_n_d;
      drv_q <= sclk_reg_q.drive_sel;
      term_q <= sclk_reg_q.term_on;
    end
  end

  // ************************************************************
  // Data capture
  // ************************************************************
  logic dclk_prev_q, dclk_edge, path_rst;
  logic [CODE_W-1:0] code_q, code_d;
  logic stb_q, stb_d, prst_q;
  logic [9:0] dly_q, dly_d;

  // Both edges capture a word; the delay itself is analog, only reported here
  assign dclk_edge = LVDS_DATA_CLOCK_IN != dclk_prev_q;
  assign path_rst = !sclk_ok || (!dclk_ok && !PATTERN_GEN_ENABLE_IN);

  always_comb
  begin
    code_d = code_q;
    stb_d = 1'b0;
    if (path_rst)
    begin
      code_d = '0;
    end
    else if (dclk_edge && dclk_ok)
    begin
      code_d = DATA_PORT_IN;
      stb_d = 1'b1;
    end
    if (dclk_reg_q.quad_sel)
    begin
      dly_d = '0;
    end
    else
    begin
      dly_d = 10'(DLY_BASE_PS + DLY_STEP_PS * int'($signed(dclk_reg_q.delay_trim)));
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      dclk_prev_q <= 1'b0;
      code_q <= '0;
      stb_q <= 1'b0;
      prst_q <= 1'b1;
      dly_q <= '0;
    end
    else
    begin
      dclk_prev_q <= LVDS_DATA_CLOCK_IN;
      code_q <= code_d;
      stb_q <= stb_d;
      prst_q <= path_rst;
      dly_q <= dly_d;
    end
  end

  assign SPI_SDO_OUT = sdo_q;
  assign SPI_SDO_OE_N_OUT = oe_n_q;
  assign DIVIDED_CLOCK_OUT = div_q;
  assign DIVCLK_OE_N_OUT = oe_div_n_q;
  assign DIVCLK_DRIVE_HI_OUT = drv_q;
  assign DIVCLK_TERM_ON_OUT = term_q;
  assign DAC_CODE_OUT = code_q;
  assign CODE_STROBE_OUT = stb_q;
  assign DATAPATH_RESET_OUT = prst_q;
  assign DCLK_DELAY_PS_OUT = dly_q;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_word_taken;
    dclk_edge && dclk_ok && !path_rst;
  endsequence

  a_ddr_capture: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    s_word_taken |=> CODE_STROBE_OUT && DAC_CODE_OUT == $past(DATA_PORT_IN))
    else $error("data word not captured on data clock edge");

  a_mid_sclk: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    !sclk_ok |=> DAC_CODE_OUT == '0 && DATAPATH_RESET_OUT)
    else $error("output not midscale without sample clock");

  a_mid_dclk: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    (!dclk_ok && !PATTERN_GEN_ENABLE_IN) |=> DAC_CODE_OUT == '0 && !CODE_STROBE_OUT)
    else $error("output not midscale without data clock");

  a_div_half: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    (sclk_rise && sclk_reg_q.ratio_sel) |=> DIVIDED_CLOCK_OUT != $past(DIVIDED_CLOCK_OUT))
    else $error("divide by two output did not toggle");

  a_div_tristate: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    sclk_reg_q.out_disable |=> DIVCLK_OE_N_OUT)
    else $error("divided clock driven while disabled");

  a_drive_term: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    ##1 (DIVCLK_DRIVE_HI_OUT == $past(sclk_reg_q.drive_sel)
      && DIVCLK_TERM_ON_OUT == $past(sclk_reg_q.term_on)))
    else $error("drive or termination does not follow register");

  a_delay_set: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    dclk_reg_q.quad_sel ##1 dclk_reg_q.quad_sel |-> DCLK_DELAY_PS_OUT == '0)
    else $error("quadrature mode shows clock delay");

  a_delay_trim: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    (!dclk_reg_q.quad_sel && dclk_reg_q.delay_trim == 3'h6)
      |=> DCLK_DELAY_PS_OUT == 10'h0e6)
    else $error("trim code does not give expected delay");

  a_rsvd_zero: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    (8'(sclk_reg_q) & ~SCLK_WR_MASK) == 8'h00 && (8'(dclk_reg_q) & ~DCLK_WR_MASK) == 8'h00)
    else $error("reserved or status bit stored");

  a_ro_status: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    (rd_load && addr_d == ADDR_SCLK_CTRL) |=> rd_q[1] == $past(sclk_ok))
    else $error("read does not show sample clock detector");

endmodule // dcic_top

// file: test/dcic_host_model.sv
/*
  Host-side model: sample clock and DDR data clock with data words.
  Assumes the core clock samples every output as an ordinary input.
*/
`timescale 1ns/1ps
module dcic_host_model
(
  // Clock
  input wire logic clk_in,
  // Control from the bench
  input wire logic sclk_run_in,
  input wire logic dclk_run_in,
  input wire logic dual_in,
  input wire logic quad_in,
  // Toward the block
  output logic sclk_out,
  output logic dclk_out,
  output logic [15:0] data_out
);
  logic [7:0] cnt_q;
  logic [7:0] idx;
  logic [7:0] cidx;

  initial
  begin
    cnt_q = 8'h00;
    sclk_out = 1'b0;
    dclk_out = 1'b0;
    data_out = 16'h0000;
  end

  // ************************************************************
  // Clocks and data, all moved shortly after the core clock edge
  // ************************************************************
  always @(posedge clk_in)
  begin
    #1;
    cnt_q = cnt_q + 8'h01;
    idx = dual_in ? cnt_q >> 3 : cnt_q >> 2;
    cidx = dual_in ? (cnt_q - 8'h04) >> 3 : (cnt_q - 8'h02) >> 2;
    sclk_out = sclk_run_in & cnt_q[1];
    if (dclk_run_in)
    begin
      // Single port: half the sample rate; dual port: a quarter
      data_out = 16'h5a3c ^ {idx, ~idx};
      // Quadrature shifts the clock by a quarter period
      dclk_out = quad_in ? cidx[0] : idx[0];
    end
    else
    begin
      // Clock stands still; data bus flips between the last word and its inverse every cycle
      dclk_out = 1'b0;
      data_out = ~data_out;
    end
  end
endmodule // dcic_host_model

// file: test/test_dcic_top.sv
/*
  Self-checking bench of the clock-side control block: serial register
  tasks, a host model for clocks and data, checks at the block's pins.
  Assumes detector windows shortened by parameters to fit a 40 MHz sampler.
*/
`timescale 1ns/1ps
module test_dcic_top
  import dcic_pkg::*;
;
  logic clk, rst_n, cs_n, sck, sdi, sdo, sdo_oe_n, sclk, dclk, pgen;
  logic sclk_run, dclk_run, dual, quad;
  logic dco, dco_oe_n, drv_hi, term_on, strobe, dp_rst;
  logic [15:0] data;
  logic [15:0] code;
  logic [9:0] dly;
  logic [7:0] rd;
  logic oe_seen;
  int mismatches, compares, n, i, t;

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ************************************************************
  // Block and host model
  // ************************************************************
  dcic_top #(.WIN_CYC_P(16), .SCLK_EDGES_P(2), .DCLK_EDGES_P(1)) i_dcic_top (
    .MCLK_IN(clk), .RSTN_IN(rst_n), .SPI_CS_N_IN(cs_n), .SPI_SCK_IN(sck),
    .SPI_SDI_IN(sdi), .SPI_SDO_OUT(sdo), .SPI_SDO_OE_N_OUT(sdo_oe_n),
    .SAMPLE_CLOCK_IN(sclk), .LVDS_DATA_CLOCK_IN(dclk), .DATA_PORT_IN(data),
    .PATTERN_GEN_ENABLE_IN(pgen), .DIVIDED_CLOCK_OUT(dco),
    .DIVCLK_OE_N_OUT(dco_oe_n), .DIVCLK_DRIVE_HI_OUT(drv_hi),
    .DIVCLK_TERM_ON_OUT(term_on), .DAC_CODE_OUT(code), .CODE_STROBE_OUT(strobe),
    .DATAPATH_RESET_OUT(dp_rst), .DCLK_DELAY_PS_OUT(dly));

  dcic_host_model i_dcic_host_model (.clk_in(clk), .sclk_run_in(sclk_run),
    .dclk_run_in(dclk_run), .dual_in(dual), .quad_in(quad), .sclk_out(sclk),
    .dclk_out(dclk), .data_out(data));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Mode 0 frame; SCK phases of three core cycles leave margin over two
  task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] wd);
    logic [15:0] f;
    f = {rw, a, wd};
    oe_seen = 1'b0;
    cs_n = 1'b0;
    for (int b = 15; b >= 0; b--)
    begin
      sdi = f[b];
      cyc(3);
      if (b < 8)
      begin
        rd[b] = sdo;
        oe_seen = oe_seen | sdo_oe_n;
      end
      sck = 1'b1;
      cyc(3);
      sck = 1'b0;
    end
    cyc(3);
    cs_n = 1'b1;
    cyc(3);
  endtask

  task automatic rreg(input logic [6:0] a, input logic [7:0] exp);
    spi(1'b1, a, 8'h00);
    // Read data must come with the output enable low, released after the frame
    chk({6'h00, sdo_oe_n, oe_seen, rd}, {6'h00, 2'b10, exp});
  endtask

  task automatic toggles(input int exp);
    logic p;
    n = 0;
    p = dco;
    repeat (32)
    begin
      @(negedge clk);
      if (dco !== p)
        n++;
      p = dco;
    end
    chk(n[15:0], exp[15:0]);
  endtask

  // Each strobe must carry the word the host held at the clock edge
  task automatic cap(input int exp);
    n = 0;
    repeat (64)
    begin
      @(negedge clk);
      if (strobe === 1'b1)
      begin
        n++;
        chk(code, data);
      end
    end
    chk(n[15:0], exp[15:0]);
  endtask

  task automatic results;
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    mismatches = 0;
    compares = 0;
    rst_n = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    pgen = 1'b0;
    sclk_run = 1'b0;
    dclk_run = 1'b0;
    dual = 1'b0;
    quad = 1'b0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    cyc(1);
    chk({6'h00, dly}, 16'(DLY_BASE_PS));
    chk({14'h0000, dp_rst, dco_oe_n}, 16'h0002);
    chk(code, 16'h0000);
    rreg(ADDR_SCLK_CTRL, 8'h00);
    rreg(ADDR_DCLK_CTRL, 8'h00);
    spi(1'b0, ADDR_SCLK_CTRL, 8'hfe);
    rreg(ADDR_SCLK_CTRL, 8'hf0);
    chk({13'h0000, dco_oe_n, drv_hi, term_on}, 16'h0007);
    spi(1'b0, 7'h05, 8'hff);
    rreg(7'h05, 8'h00);
    spi(1'b0, ADDR_SCLK_CTRL, 8'h00);
    chk({13'h0000, dco_oe_n, drv_hi, term_on}, 16'h0000);
    sclk_run = 1'b1;
    cyc(50);
    rreg(ADDR_SCLK_CTRL, 8'h02);
    toggles(4);
    spi(1'b0, ADDR_SCLK_CTRL, 8'h20);
    toggles(8);
    spi(1'b0, ADDR_SCLK_CTRL, 8'h01);
    rreg(ADDR_SCLK_CTRL, 8'h01);
    toggles(0);
    spi(1'b0, ADDR_SCLK_CTRL, 8'h00);
    quad = 1'b1;
    dclk_run = 1'b1;
    cyc(50);
    rreg(ADDR_DCLK_CTRL, 8'h00);
    spi(1'b0, ADDR_DCLK_CTRL, 8'h8f);
    cyc(50);
    rreg(ADDR_DCLK_CTRL, 8'h07);
    chk({5'h00, dp_rst, dly}, 16'h0000);
    cap(16);
    quad = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      spi(1'b0, ADDR_DCLK_CTRL, {1'b0, i[2:0], 4'h1});
      t = (i < 4) ? i : i - 8;
      chk({6'h00, dly}, 16'(DLY_BASE_PS + DLY_STEP_PS * t));
    end
    cap(16);
    dual = 1'b1;
    cyc(50);
    cap(8);
    dclk_run = 1'b0;
    cyc(50);
    rreg(ADDR_DCLK_CTRL, 8'h71);
    chk(code, 16'h0000);
    chk({15'h0000, dp_rst}, 16'h0001);
    pgen = 1'b1;
    cyc(3);
    chk({15'h0000, dp_rst}, 16'h0000);
    sclk_run = 1'b0;
    cyc(50);
    chk({15'h0000, dp_rst}, 16'h0001);
    chk(code, 16'h0000);
    results;
  end

  // Whole sequence needs a few thousand cycles; allow twenty thousand
  initial
  begin
    #500000;
    mismatches++;
    results;
  end
endmodule // test_dcic_top
